// file: src/ccd_top.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_top (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire ccd_pkg::ccd_reg_req_s reg_req_i,
    input wire logic comp_raw_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output ccd_pkg::ccd_func_e channel_function_field_o,
    output ccd_pkg::ccd_range_e first_conversion_range_o,
    output ccd_pkg::ccd_conv1_sel_e first_conversion_input_sel_o,
    output ccd_pkg::ccd_conv2_sel_e second_conversion_input_sel_o,
    output ccd_pkg::ccd_buf_pwr_s buf_pwr_o,
    output logic comparator_en_o,
    output logic comparator_invert_o,
    output logic sink_range_o,
    output logic [4:0] sink_code_o,
    output logic sink_on_o,
    output logic [12:0] sink_current_ua_o,
    output logic din_debounced_o,
    output logic [15:0] din_count_o
);
    import ccd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // register state
    logic [3:0] channel_function_field_r;
    logic [15:0] conv_r;
    logic [4:0] pwr_r;
    logic [15:0] din1_r;
    logic [15:0] rdata_r;
    logic rvalid_r;
    logic [15:0] conv_nxt;
    logic [15:0] din1_nxt;
    logic [15:0] rdata_nxt;

    // decoded outputs, one flop behind the registers
    ccd_func_e func_out_r;
    ccd_range_e range_out_r;
    ccd_conv1_sel_e c1_sel_r;
    ccd_conv2_sel_e c2_sel_r;
    ccd_buf_pwr_s buf_pwr_r;
    logic comp_en_r;
    logic invert_r;
    logic sink_range_r;
    logic [4:0] sink_code_r;
    logic sink_on_r;
    logic [12:0] sink_ua_r;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode
    logic hit_func;
    logic hit_conv;
    logic hit_pwr;
    logic hit_din1;
    logic new_is_din;
    logic [15:0] din_count;
    logic db_level;

    assign hit_func = reg_req_i.wr && (reg_req_i.addr == OFF_CHANNEL_FUNCTION_FIELD);
    assign hit_conv = reg_req_i.wr && (reg_req_i.addr == OFF_CONV);
    assign hit_pwr = reg_req_i.wr && (reg_req_i.addr == OFF_PWR);
    assign hit_din1 = reg_req_i.wr && (reg_req_i.addr == OFF_DIN1);
    // digital input functions want the comparator running
    assign new_is_din = (ccd_decode_func(reg_req_i.wdata[3:0]) == CCD_FN_DIN_LOGIC) ||
        (ccd_decode_func(reg_req_i.wdata[3:0]) == CCD_FN_DIN_LOOP);

    ////////////////////////////////////////////////////////////////////////////////
    // next values; a function write reshapes the other two registers
    // the host is trusted to halt conversions before touching conv_r
    always_comb begin
        conv_nxt = conv_r;
        din1_nxt = din1_r;
        if (hit_conv) begin
            conv_nxt = reg_req_i.wdata;
        end else if (hit_func) begin
            conv_nxt[FIRST_CONVERSION_RANGE_LSB +: 3] = 3'h0;
            conv_nxt[CONV1_SEL_LSB +: 2] = 2'h0;
        end
        if (hit_din1) begin
            din1_nxt = reg_req_i.wdata & MASK_DIN1;
        end else if (hit_func) begin
            din1_nxt[SINK_LSB +: 5] = 5'h00;
            din1_nxt[COMP_EN_BIT] = new_is_din;
        end
    end

    // read mux; unmapped offsets read zero
    assign rdata_nxt =
        (reg_req_i.addr == OFF_CHANNEL_FUNCTION_FIELD) ? {12'h000, channel_function_field_r} :
        (reg_req_i.addr == OFF_CONV) ? conv_r :
        (reg_req_i.addr == OFF_PWR) ? {11'h000, pwr_r} :
        (reg_req_i.addr == OFF_DIN1) ? din1_r :
        (reg_req_i.addr == OFF_COUNT) ? din_count : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // register file
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            channel_function_field_r <= RST_CHANNEL_FUNCTION_FIELD;
            conv_r <= RST_CONV;
            pwr_r <= RST_PWR;
            din1_r <= RST_DIN1;
        end else begin
            channel_function_field_r <= hit_func ? reg_req_i.wdata[3:0] : channel_function_field_r;
            conv_r <= conv_nxt;
            pwr_r <= hit_pwr ? reg_req_i.wdata[4:0] : pwr_r;
            din1_r <= din1_nxt;
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= reg_req_i.rd ? rdata_nxt : rdata_r;
            rvalid_r <= reg_req_i.rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decoded control outputs
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            func_out_r <= CCD_FN_HIGH_Z;
            range_out_r <= CCD_RNG_0_12V;
            c1_sel_r <= CCD_C1_LOW_GND;
            c2_sel_r <= CCD_C2_EXT1_GND;
        end else begin
            func_out_r <= ccd_decode_func(channel_function_field_r);
            range_out_r <= ccd_decode_range(conv_r[FIRST_CONVERSION_RANGE_LSB +: 3]);
            c1_sel_r <= ccd_conv1_sel_e'(conv_r[CONV1_SEL_LSB +: 2]);
            c2_sel_r <= ccd_conv2_sel_e'(conv_r[CONV2_SEL_LSB +: 2]);
        end
    end

    // buffer power and sink drive
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            buf_pwr_r <= ccd_buf_pwr_s'(RST_PWR);
            comp_en_r <= 1'b0;
            invert_r <= 1'b0;
            sink_range_r <= 1'b0;
            sink_code_r <= 5'h00;
            sink_on_r <= 1'b0;
            sink_ua_r <= 13'h0000;
        end else begin
            buf_pwr_r <= ccd_buf_pwr_s'(pwr_r);
            comp_en_r <= din1_r[COMP_EN_BIT];
            invert_r <= din1_r[INVERT_BIT];
            sink_range_r <= din1_r[SINK_RANGE_BIT];
            sink_code_r <= din1_r[SINK_LSB +: 5];
            sink_on_r <= (din1_r[SINK_LSB +: 5] != 5'h00);
            sink_ua_r <= 13'(din1_r[SINK_LSB +: 5] *
                (din1_r[SINK_RANGE_BIT] ? SINK_STEP1_UA : SINK_STEP0_UA));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // comparator path: disabled comparator reads low, inversion applied first
    logic cmp_eff;
    assign cmp_eff = din1_r[COMP_EN_BIT] ? (comp_raw_i ^ din1_r[INVERT_BIT]) : 1'b0;

    ccd_debounce u_debounce (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .sample_i(cmp_eff),
        .mode_i(din1_r[DB_MODE_BIT]),
        .time_i(din1_r[DB_TIME_LSB +: 5]),
        .level_o(db_level)
    );

    ccd_edge_counter u_counter (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(db_level),
        .falling_i(din1_r[INVERT_BIT]),
        .en_i(din1_r[COUNT_EN_BIT]),
        .count_o(din_count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // output drive
    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;
    assign channel_function_field_o = func_out_r;
    assign first_conversion_range_o = range_out_r;
    assign first_conversion_input_sel_o = c1_sel_r;
    assign second_conversion_input_sel_o = c2_sel_r;
    assign buf_pwr_o = buf_pwr_r;
    assign comparator_en_o = comp_en_r;
    assign comparator_invert_o = invert_r;
    assign sink_range_o = sink_range_r;
    assign sink_code_o = sink_code_r;
    assign sink_on_o = sink_on_r;
    assign sink_current_ua_o = sink_ua_r;
    assign din_debounced_o = db_level;
    assign din_count_o = din_count;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_func_clears_sink: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        hit_func ##1 !hit_din1 |=> ##1 sink_code_o == 5'h00 && !sink_on_o)
        else $error("sink not cleared by function write");
    a_range_default: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        conv_r[FIRST_CONVERSION_RANGE_LSB +: 3] == 3'h7 |=> first_conversion_range_o == CCD_RNG_0_12V)
        else $error("spare range code not 0..12 V");
    a_func_unlisted: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        channel_function_field_r > 4'h9 |=> channel_function_field_o == CCD_FN_HIGH_Z)
        else $error("unlisted function not high impedance");
    a_buf_after_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(rst_n_i) |-> pwr_r == RST_PWR && din1_r == RST_DIN1)
        else $error("reset values wrong");
    a_sink_scale: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        din1_r[SINK_RANGE_BIT] && din1_r[SINK_LSB +: 5] == 5'h1F
        |=> sink_current_ua_o == 13'd7440) else $error("range 1 full scale wrong");
    a_func_reshapes: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        hit_func |=> conv_r[FIRST_CONVERSION_RANGE_LSB +: 3] == 3'h0 &&
        din1_r[COMP_EN_BIT] == $past(new_is_din))
        else $error("function write side effects wrong");
    a_invert_path: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        din1_r[COMP_EN_BIT] |-> cmp_eff == (comp_raw_i ^ din1_r[INVERT_BIT]))
        else $error("comparator inversion wrong");
    a_c2_select: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        conv_r[CONV2_SEL_LSB +: 2] == 2'h3 |=> second_conversion_input_sel_o == CCD_C2_GND_GND)
        else $error("conversion 2 select wrong");
endmodule
`default_nettype wire

// file: shared/ccd_pkg.sv
// Contract
// - conversion-1 range code 000..110 picks the seven ranges; other codes give 0..12 V
// - a channel function write may overwrite the conversion-1 range field
// - conversion-2 input select: ext1/gnd, ext2/gnd, ext2/ext1, gnd/gnd
// - conversion-1 input select has four node pairs; a function write may alter it
// - five sense buffers: 0 low power, 1 full power, all reset to 1
// - counter enabled counts rising debounced edges, or falling edges when inverted
// - inversion bit inverts the comparator output before further use
// - comparator enable turns comparator on; a function write may change it
// - sink range bit: 0 gives 120 uA steps, 1 gives 240 uA steps
// - five-bit sink code programs the sink; zero switches it off
// - every channel function write clears the sink code
// - debounce mode 0 integrates: count up when asserted, down when not
// - debounce mode 1 counts up while asserted, back to zero on deassert
// - debounce time resets to 0xB (240 us); code zero bypasses the debouncer
// - channel function field selects function; reset and unlisted codes give high impedance
package ccd_pkg;
    // register offsets on the register port
    localparam logic [7:0] OFF_CHANNEL_FUNCTION_FIELD = 8'h01;
    localparam logic [7:0] OFF_CONV = 8'h02;
    localparam logic [7:0] OFF_PWR = 8'h03;
    localparam logic [7:0] OFF_DIN1 = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h10;
    // values after reset
    localparam logic [3:0] RST_CHANNEL_FUNCTION_FIELD = 4'h0;
    localparam logic [15:0] RST_CONV = 16'h2400;
    localparam logic [4:0] RST_PWR = 5'h1F;
    localparam logic [15:0] RST_DIN1 = 16'h000B;
    // writable bits of the digital input register, bit 5 reserved
    localparam logic [15:0] MASK_DIN1 = 16'hFFDF;
    // field positions
    localparam int FIRST_CONVERSION_RANGE_LSB = 4;
    localparam int CONV2_SEL_LSB = 2;
    localparam int CONV1_SEL_LSB = 0;
    localparam int COUNT_EN_BIT = 15;
    localparam int INVERT_BIT = 14;
    localparam int COMP_EN_BIT = 13;
    localparam int SINK_RANGE_BIT = 12;
    localparam int SINK_LSB = 7;
    localparam int DB_MODE_BIT = 6;
    localparam int DB_TIME_LSB = 0;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int DB_TICK_NS = 1000;
    localparam int DB_TICK_CYC = (DB_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DB_REF_CODE = 11;
    localparam int DB_REF_US = 240;
    localparam int SINK_STEP0_UA = 120;
    localparam int SINK_STEP1_UA = 240;

    typedef enum logic [2:0] {
        CCD_RNG_0_12V, CCD_RNG_PM12V, CCD_RNG_PM2V5, CCD_RNG_N2V5_0,
        CCD_RNG_0_2V5, CCD_RNG_0_625MV, CCD_RNG_PM104MV
    } ccd_range_e;
    typedef enum logic [1:0] {
        CCD_C2_EXT1_GND, CCD_C2_EXT2_GND, CCD_C2_EXT2_EXT1, CCD_C2_GND_GND
    } ccd_conv2_sel_e;
    typedef enum logic [1:0] {
        CCD_C1_LOW_GND, CCD_C1_HIGH_LOW, CCD_C1_EXT2_EXT1, CCD_C1_LOW_EXT1
    } ccd_conv1_sel_e;
    typedef enum logic [3:0] {
        CCD_FN_HIGH_Z, CCD_FN_VOUT, CCD_FN_IOUT, CCD_FN_VIN, CCD_FN_IIN_EXT,
        CCD_FN_IIN_LOOP, CCD_FN_RES_2W, CCD_FN_RES_34W, CCD_FN_DIN_LOGIC,
        CCD_FN_DIN_LOOP
    } ccd_func_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ccd_reg_req_s;
    typedef struct packed {
        logic ground_sense_buffer_power;
        logic low_side_buffer_power;
        logic high_side_buffer_power;
        logic external_two_buffer_power;
        logic external_one_buffer_power;
    } ccd_buf_pwr_s;

    function automatic ccd_range_e ccd_decode_range(input logic [2:0] code);
        ccd_range_e r;
        r = (code == 3'h7) ? CCD_RNG_0_12V : ccd_range_e'(code);
        return r;
    endfunction

    function automatic ccd_func_e ccd_decode_func(input logic [3:0] code);
        ccd_func_e f;
        f = (code > 4'h9) ? CCD_FN_HIGH_Z : ccd_func_e'(code);
        return f;
    endfunction

    // terminal count in debounce ticks, scaled so that the reset code gives 240 us
    function automatic logic [9:0] ccd_db_terminal(input logic [4:0] code);
        int t;
        t = (int'(code) * DB_REF_US + DB_REF_CODE / 2) / DB_REF_CODE;
        return t[9:0];
    endfunction
endpackage

// file: src/ccd_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_debounce (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic sample_i,
    input wire logic mode_i,
    input wire logic [4:0] time_i,
    output logic level_o
);
    import ccd_pkg::*;

    logic [5:0] tick_cnt_r;
    logic [9:0] cnt_r;
    logic level_r;
    logic tick;
    logic bypass;
    logic [9:0] term;
    logic [9:0] cnt_nxt;
    logic level_nxt;

    // sample strobe; the tick sets the time base of every nonzero debounce code
    assign tick = (tick_cnt_r == 6'(DB_TICK_CYC - 1));
    assign bypass = (time_i == 5'h00);
    assign term = ccd_db_terminal(time_i);
    // mode 0 walks both ways, mode 1 drops straight to zero on deassert
    assign cnt_nxt = sample_i ? ((cnt_r < term) ? cnt_r + 10'h001 : cnt_r)
        : (mode_i ? 10'h000 : ((cnt_r != 10'h000) ? cnt_r - 10'h001 : cnt_r));
    // output moves only at the two ends of the count
    assign level_nxt = (cnt_nxt >= term) ? 1'b1 :
        ((cnt_nxt == 10'h000) ? 1'b0 : level_r);
    assign level_o = level_r;

    // tick divider
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || tick) begin
            tick_cnt_r <= 6'h00;
        end else begin
            tick_cnt_r <= tick_cnt_r + 6'h01;
        end
    end

    // bypass passes the raw level with one flop of delay
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_r <= 10'h000;
            level_r <= 1'b0;
        end else if (bypass) begin
            cnt_r <= 10'h000;
            level_r <= sample_i;
        end else if (tick) begin
            cnt_r <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    a_bypass_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        bypass |=> level_r == $past(sample_i)) else $error("bypass level wrong");
    a_integrator_down: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        tick && !bypass && !mode_i && !sample_i && cnt_r != 10'h000
        |=> cnt_r == $past(cnt_r) - 10'h001) else $error("no decrement");
    a_simple_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        tick && !bypass && mode_i && !sample_i |=> cnt_r == 10'h000)
        else $error("mode 1 count not cleared");
    a_rise_at_term: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(level_r) && !$past(bypass) |-> cnt_r >= $past(term))
        else $error("level rose early");
endmodule
`default_nettype wire

// file: src/ccd_edge_counter.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_edge_counter (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    input wire logic falling_i,
    input wire logic en_i,
    output logic [15:0] count_o
);
    import ccd_pkg::*;

    logic prev_r;
    logic [15:0] count_r;
    logic edge_hit;

    // edge polarity follows the inversion bit; count wraps at full scale
    assign edge_hit = en_i && (falling_i ? (prev_r && !level_i) : (!prev_r && level_i));
    assign count_o = count_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            prev_r <= 1'b0;
            count_r <= 16'h0000;
        end else begin
            prev_r <= level_i;
            count_r <= edge_hit ? count_r + 16'h0001 : count_r;
        end
    end

    a_count_edge: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        en_i && !falling_i && $rose(level_i) && $past(rst_n_i)
        |=> count_r == $past(count_r) + 16'h0001) else $error("rising edge lost");
    a_count_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !en_i |=> $stable(count_r)) else $error("counted while off");
endmodule
`default_nettype wire

// file: verification/ccd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccd_host_model (
    input wire logic ref_clk_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output var ccd_pkg::ccd_reg_req_s req_o
);
    import ccd_pkg::*;
    // bus idles with no strobe
    initial begin
        req_o = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // write held across its taking edge; caller keeps conversions stopped
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk_i);
        // released lines show inverted leftovers, never the last value
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // read answer lands on the taking edge and is sampled at the next falling edge
    task automatic read(input logic [7:0] a, output logic [15:0] d, output logic ok);
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req_o.wdata};
        @(negedge ref_clk_i);
        // valid stands for one cycle only, so take it before the next edge
        ok = rvalid_i;
        d = rdata_i;
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req_o.wdata};
    endtask
endmodule
`default_nettype wire

// file: verification/channel_config_and_din_debounce_test.sv
`timescale 1ns/1ps
`default_nettype none
module channel_config_and_din_debounce_test;
    import ccd_pkg::*;
    localparam int TICK = 40;
    localparam int TERM = (1 * 240 + 5) / 11;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic comp_raw_i = 1'b0;
    ccd_reg_req_s req;
    logic [15:0] rdata;
    logic rvalid;
    ccd_func_e fn_o;
    ccd_range_e rng_o;
    ccd_conv1_sel_e s1_o;
    ccd_conv2_sel_e s2_o;
    ccd_buf_pwr_s pwr_o;
    logic cen_o, inv_o, srng_o, son_o, deb_o;
    logic [4:0] scode_o;
    logic [12:0] sua_o;
    logic [15:0] cnt_o;
    int failures = 0;
    int num_checks = 0;
    logic [15:0] mdl [0:4];
    int cnt_m = 0;

    // 40 MHz clock
    always #12.5 ref_clk_i = ~ref_clk_i;

    ccd_host_model host_u (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

    ccd_top dut_u (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .comp_raw_i(comp_raw_i),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .channel_function_field_o(fn_o),
        .first_conversion_range_o(rng_o), .first_conversion_input_sel_o(s1_o),
        .second_conversion_input_sel_o(s2_o), .buf_pwr_o(pwr_o), .comparator_en_o(cen_o),
        .comparator_invert_o(inv_o), .sink_range_o(srng_o), .sink_code_o(scode_o),
        .sink_on_o(son_o), .sink_current_ua_o(sua_o), .din_debounced_o(deb_o),
        .din_count_o(cnt_o)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic err(input string m);
        failures++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    function automatic logic [15:0] exp_rd(input logic [7:0] a);
        if (a >= 8'h01 && a <= 8'h04) return mdl[a[2:0]];
        return (a == 8'h10) ? cnt_m[15:0] : 16'h0;
    endfunction
    task automatic chk_reg(input logic [7:0] a);
        logic [15:0] d;
        logic ok;
        host_u.read(a, d, ok);
        num_checks++;
        if (ok !== 1'b1 || d !== exp_rd(a)) err($sformatf("read %h got %h", a, d));
    endtask
    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp) err($sformatf("%s got %h want %h", m, got, exp));
    endtask
    // model follows every write, including the side effects of a function write
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        host_u.write(a, d);
        case (a)
            8'h01: begin
                mdl[1] = d & 16'h000F;
                mdl[2] = mdl[2] & 16'hFF8C;
                mdl[4] = (mdl[4] & 16'hD07F) | ((d[3:1] == 3'h4) ? 16'h2000 : 16'h0);
            end
            8'h02: mdl[2] = d;
            8'h03: mdl[3] = d & 16'h001F;
            8'h04: mdl[4] = d & 16'hFFDF;
            default: ;
        endcase
    endtask
    // decoded outputs trail their register by one cycle
    task automatic chk_outs();
        logic [3:0] f;
        logic [2:0] r;
        logic [4:0] s;
        f = mdl[1][3:0];
        r = mdl[2][6:4];
        s = mdl[4][11:7];
        repeat (3) @(negedge ref_clk_i);
        chk_pin(16'(fn_o), (f > 4'h9) ? 16'h0 : 16'(f), "function");
        chk_pin(16'(rng_o), (r == 3'h7) ? 16'h0 : 16'(r), "range");
        chk_pin(16'(s1_o), 16'(mdl[2][1:0]), "sel one");
        chk_pin(16'(s2_o), 16'(mdl[2][3:2]), "sel two");
        chk_pin(16'(pwr_o), 16'(mdl[3][4:0]), "buffers");
        chk_pin(16'({inv_o, cen_o, srng_o}), 16'(mdl[4][14:12]), "din bits");
        chk_pin(16'({son_o, scode_o}), 16'({|s, s}), "sink");
        chk_pin(16'(sua_o), 16'(s) * (mdl[4][12] ? 16'd240 : 16'd120), "current");
    endtask
    task automatic wait_deb(input logic v, output int n);
        n = 0;
        while (deb_o !== v && n < 2000) begin
            @(negedge ref_clk_i);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int n;
        logic b;
        void'($urandom(32'h1ba11b03));
        mdl = '{16'h0, 16'h0, 16'h2400, 16'h001F, 16'h000B};
        repeat (8) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        for (int a = 0; a < 6; a++) chk_reg(8'(a));
        chk_outs();
        // every range code including the unlisted one, random selectors
        for (int i = 0; i < 8; i++) begin
            reg_wr(8'h02, ($urandom & 16'hFF8F) | 16'(i << 4));
            chk_outs();
            chk_reg(8'h02);
        end
        // random setups; counting stays off so the count is still zero
        repeat (6) begin
            reg_wr(8'h03, 16'($urandom));
            reg_wr(8'h04, 16'($urandom & 16'h7FFF));
            chk_reg(8'h03);
            chk_reg(8'h04);
            chk_outs();
        end
        // every function code clears sink and conv1 fields
        for (int f = 0; f < 16; f++) begin
            reg_wr(8'h04, 16'h0F80 | 16'($urandom & 16'h7FFF));
            reg_wr(8'h02, 16'($urandom));
            reg_wr(8'h01, 16'($urandom & 16'hFFF0) | 16'(f));
            chk_outs();
            chk_reg(8'h01);
            chk_reg(8'h02);
            chk_reg(8'h04);
        end
        // read-only count and an unmapped place ignore writes
        reg_wr(8'h10, 16'hFFFF);
        reg_wr(8'h07, 16'($urandom));
        chk_reg(8'h10);
        chk_reg(8'h07);
        // bypass passes the raw level; counting is armed only once the level is stable
        for (int inv = 0; inv < 2; inv++) begin
            reg_wr(8'h04, 16'h2000 | 16'(inv << 14));
            repeat (4) @(negedge ref_clk_i);
            reg_wr(8'h04, 16'hA000 | 16'(inv << 14));
            repeat (20) begin
                b = 1'($urandom);
                if (b && !comp_raw_i) cnt_m++;
                comp_raw_i = b;
                repeat (4) @(negedge ref_clk_i);
                chk_pin(16'(deb_o), 16'(b ^ inv[0]), "bypass");
            end
            repeat (3) @(negedge ref_clk_i);
            chk_pin(cnt_o, cnt_m[15:0], "count");
            chk_reg(8'h10);
        end
        // both debounce methods with a 22-tick terminal
        for (int m = 0; m < 2; m++) begin
            comp_raw_i = 1'b0;
            reg_wr(8'h04, 16'h2001 | 16'(m << 6));
            repeat (30 * TICK) @(negedge ref_clk_i);
            chk_pin(16'(deb_o), 16'h0, "settled");
            comp_raw_i = 1'b1;
            wait_deb(1'b1, n);
            chk_pin(16'(n >= (TERM - 1) * TICK && n <= (TERM + 2) * TICK), 16'h1, "rise");
            comp_raw_i = 1'b0;
            if (m == 0) begin
                repeat (10 * TICK) @(negedge ref_clk_i);
                chk_pin(16'(deb_o), 16'h1, "integrate");
                wait_deb(1'b0, n);
                chk_pin(16'(n <= (TERM - 8) * TICK), 16'h1, "fall");
            end else begin
                wait_deb(1'b0, n);
                chk_pin(16'(n <= 2 * TICK), 16'h1, "reset");
            end
        end
        test_done();
    end
    // watchdog
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        err("timeout");
        test_done();
    end
endmodule
`default_nettype wire
